// ### common/rmpc_pkg.sv
// Purpose: Shared constants and types for the reset, mode and power control block
// Assumes: 50 MHz system clock, 8-bit register port with a 4-bit address
// Notes: Register offsets, field positions and reset values are named here only
package rmpc_pkg;

  // System clock period and the time the reset pin is driven low after an internal cause
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int RESET_DRIVE_NS = 320;
  localparam int RESET_DRIVE_CYCLES = (RESET_DRIVE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DRIVE_CNT_W = 6;

  // Register offsets on the plain port
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_GATE = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;

  // Field positions of the control register
  localparam int CTRL_OSC_SEL = 0;
  localparam int CTRL_PSTOP_SEL = 1;
  localparam int CTRL_CAN_WAKE = 2;
  localparam int CTRL_FREEZE = 3;
  localparam int CTRL_DEBUG_EXIT = 4;

  // Field positions of the status register
  localparam int STAT_POWER_LSB = 0;
  localparam int STAT_SECURED = 2;
  localparam int STAT_DEBUG = 3;
  localparam int STAT_CAUSE_LSB = 4;

  // Reset value of the gate register and the unsecured security code
  localparam logic [7:0] GATE_RESET = 8'hFF;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;

  // Mode strap encodings
  localparam logic MODE_NORMAL = 1'b1;
  localparam logic MODE_SPECIAL = 1'b0;

  typedef enum logic [1:0] {
    RMPC_PHASE_HOLD = 2'b00,
    RMPC_PHASE_CAPTURE = 2'b01,
    RMPC_PHASE_RUN = 2'b10,
    RMPC_PHASE_DRIVE = 2'b11
  } rmpc_phase_type;

  typedef enum logic [1:0] {
    RMPC_PWR_RUN = 2'b00,
    RMPC_PWR_WAIT = 2'b01,
    RMPC_PWR_PSTOP = 2'b10,
    RMPC_PWR_STOP = 2'b11
  } rmpc_power_type;

  typedef enum logic [1:0] {
    RMPC_CAUSE_PIN = 2'b00,
    RMPC_CAUSE_WATCHDOG = 2'b01,
    RMPC_CAUSE_CLKMON = 2'b10
  } rmpc_cause_type;

  // Wake and interrupt inputs, all from logic on the system clock
  typedef struct packed {
    logic nonmaskable_irq_input;
    logic maskable_irq;
    logic ccr_irq_mask;
    logic unmasked_irq_pending;
    logic periodic_tick_interrupt;
    logic watchdog_timer_wake;
    logic autonomous_wakeup_timer;
    logic can_controller_wake;
  } rmpc_wake_type;

  // Clock gating outputs
  typedef struct packed {
    logic cpu_clock_en;
    logic osc_run;
    logic tick_wdog_clock_en;
    logic api_clock_en;
    logic use_crystal;
    logic crystal_pins_gpio;
    logic [7:0] periph_clock_en;
  } rmpc_clocks_type;

  // Debug and security outputs
  typedef struct packed {
    logic background_debug_state;
    logic freeze_active;
    logic debug_full;
    logic debug_restricted;
    logic nvm_external_access;
    logic nvm_cmd_restricted;
  } rmpc_debug_type;

endpackage

// ### src/rmpc_reset_sync.sv
// Purpose: Releases the asynchronous board reset through two flip-flops
// Assumes: Reset is active low and may arrive at any time
// Notes: Assertion is immediate, release is aligned to the clock
`timescale 1ns/1ps
module rmpc_reset_sync (
  input wire logic clock,
  input wire logic rst_n,
  output logic rst_sync_n
);

  logic [1:0] stages;

  // Two stages keep a late release from going metastable into the design
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stages <= 2'h0;
    end else begin
      stages <= {stages[0], 1'b1};
    end
  end

  assign rst_sync_n = stages[1];

endmodule

// ### src/rmpc_top.sv
// Purpose: Reset pin handling, mode strap capture, power mode sequencing, debug freeze and security gating
// Assumes: Register port and wake inputs are on the system clock; reset pin and strap are asynchronous pins
// Notes: All state but the two reset synchronizer flops sits in one packed struct, filled by one combinational process
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module rmpc_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic debug_line_pin_in,
  output logic debug_line_pin_out,
  output logic debug_line_pin_oe,
  input wire logic watchdog_timer_reset,
  input wire logic clock_monitor_reset,
  input wire logic [1:0] security_bits,
  input wire logic wait_instruction,
  input wire logic stop_instruction,
  input wire rmpc_pkg::rmpc_wake_type wake,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic sys_reset_n,
  output logic fetch_reset_vector,
  output rmpc_pkg::rmpc_clocks_type clocks,
  output rmpc_pkg::rmpc_debug_type debug
);

  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic strap_meta;
    logic strap_sync;
    rmpc_pkg::rmpc_phase_type phase;
    logic [rmpc_pkg::DRIVE_CNT_W-1:0] drive_cnt;
    rmpc_pkg::rmpc_cause_type cause;
    logic mode_strap_bit;
    logic secured;
    logic debug_state;
    logic fetch_pulse;
    rmpc_pkg::rmpc_power_type power;
    logic osc_sel;
    logic pstop_sel;
    logic can_wake_en;
    logic freeze_en;
    logic [7:0] periph_gate;
    logic [7:0] rdata;
  } rmpc_state_type;

  localparam logic [rmpc_pkg::DRIVE_CNT_W-1:0] DRIVE_LOAD = rmpc_pkg::DRIVE_CNT_W'(rmpc_pkg::RESET_DRIVE_CYCLES);

  // Constant reset image; the mode bit defaults to normal until the first capture
  localparam rmpc_state_type STATE_RESET = '{
    pin_meta: 1'b0,
    pin_sync: 1'b0,
    strap_meta: 1'b1,
    strap_sync: 1'b1,
    phase: rmpc_pkg::RMPC_PHASE_HOLD,
    drive_cnt: '0,
    cause: rmpc_pkg::RMPC_CAUSE_PIN,
    mode_strap_bit: rmpc_pkg::MODE_NORMAL,
    secured: 1'b1,
    debug_state: 1'b0,
    fetch_pulse: 1'b0,
    power: rmpc_pkg::RMPC_PWR_RUN,
    osc_sel: 1'b0,
    pstop_sel: 1'b0,
    can_wake_en: 1'b0,
    freeze_en: 1'b0,
    periph_gate: rmpc_pkg::GATE_RESET,
    rdata: 8'h00
  };

  rmpc_state_type state;
  rmpc_state_type next_state;
  logic rst_sync_n;
  logic running;
  logic wake_wait;
  logic wake_pstop;
  logic wake_stop;
  logic maskable_ok;

  rmpc_reset_sync u_reset_sync (
    .clock(clock),
    .rst_n(rst_n),
    .rst_sync_n(rst_sync_n)
  );

  // Security decode, used at capture only; status read returns the captured bit
  function automatic logic rmpc_is_secured(input logic [1:0] bits);
    rmpc_is_secured = (bits != rmpc_pkg::SEC_UNSECURED);
  endfunction

  // Address match for a write strobe
  function automatic logic rmpc_wr_hit(input logic strobe, input logic [3:0] addr, input logic [3:0] reg_off);
    rmpc_wr_hit = strobe && (addr == reg_off);
  endfunction

  assign running = (state.phase == rmpc_pkg::RMPC_PHASE_RUN);
  assign maskable_ok = wake.maskable_irq && !wake.ccr_irq_mask;

  // Wake sources per low power mode; reset ends every mode through the phase machine
  assign wake_wait = wake.nonmaskable_irq_input || maskable_ok || wake.unmasked_irq_pending;
  assign wake_pstop = wake.nonmaskable_irq_input || maskable_ok || wake.periodic_tick_interrupt
                      || wake.watchdog_timer_wake || wake.autonomous_wakeup_timer;
  assign wake_stop = wake.nonmaskable_irq_input || maskable_ok || wake.autonomous_wakeup_timer
                     || (state.can_wake_en && wake.can_controller_wake);

  // Next state of the whole block
  always_comb begin
    next_state = state;
    next_state.fetch_pulse = 1'b0;
    // Pins pass two flops; only the second stage is looked at below
    next_state.pin_meta = reset_pin_in;
    next_state.pin_sync = state.pin_meta;
    next_state.strap_meta = debug_line_pin_in;
    next_state.strap_sync = state.strap_meta;

    case (state.phase)
      rmpc_pkg::RMPC_PHASE_HOLD: begin
        // Pin held low by the outside party or released after our own drive
        if (state.pin_sync) begin
          next_state.phase = rmpc_pkg::RMPC_PHASE_CAPTURE;
          // Strap and pin share the same delay, so this is the level at the pin's rising edge
          next_state.mode_strap_bit = state.strap_sync;
          next_state.secured = rmpc_is_secured(security_bits);
        end
      end
      rmpc_pkg::RMPC_PHASE_CAPTURE: begin
        // Internal reset lifts one cycle after the capture
        next_state.phase = rmpc_pkg::RMPC_PHASE_RUN;
        next_state.debug_state = (state.mode_strap_bit == rmpc_pkg::MODE_SPECIAL);
        next_state.fetch_pulse = (state.mode_strap_bit == rmpc_pkg::MODE_NORMAL);
      end
      rmpc_pkg::RMPC_PHASE_RUN: begin
        if (!state.pin_sync) begin
          next_state.phase = rmpc_pkg::RMPC_PHASE_HOLD;
          next_state.cause = rmpc_pkg::RMPC_CAUSE_PIN;
        end else if (watchdog_timer_reset || clock_monitor_reset) begin
          next_state.phase = rmpc_pkg::RMPC_PHASE_DRIVE;
          next_state.drive_cnt = DRIVE_LOAD;
          next_state.cause = watchdog_timer_reset ? rmpc_pkg::RMPC_CAUSE_WATCHDOG : rmpc_pkg::RMPC_CAUSE_CLKMON;
        end
      end
      rmpc_pkg::RMPC_PHASE_DRIVE: begin
        // Pin is driven low for a fixed count, then the pull-up brings it back
        if (state.drive_cnt <= 1) begin
          next_state.phase = rmpc_pkg::RMPC_PHASE_HOLD;
          next_state.drive_cnt = '0;
        end else begin
          next_state.drive_cnt = state.drive_cnt - 1'b1;
        end
      end
      default: begin
        next_state.phase = rmpc_pkg::RMPC_PHASE_HOLD;
      end
    endcase

    // Any reset returns the chip to its start-up settings, the captured mode excepted
    if (!running) begin
      next_state.power = rmpc_pkg::RMPC_PWR_RUN;
      next_state.osc_sel = 1'b0;
      next_state.pstop_sel = 1'b0;
      next_state.can_wake_en = 1'b0;
      next_state.freeze_en = 1'b0;
      next_state.periph_gate = rmpc_pkg::GATE_RESET;
      if (state.phase != rmpc_pkg::RMPC_PHASE_CAPTURE) begin
        next_state.debug_state = 1'b0;
      end
      next_state.rdata = 8'h00;
    end else begin
      // Power mode sequencing
      case (state.power)
        rmpc_pkg::RMPC_PWR_RUN: begin
          if (wait_instruction) begin
            next_state.power = rmpc_pkg::RMPC_PWR_WAIT;
          end else if (stop_instruction) begin
            next_state.power = state.pstop_sel ? rmpc_pkg::RMPC_PWR_PSTOP : rmpc_pkg::RMPC_PWR_STOP;
          end
        end
        rmpc_pkg::RMPC_PWR_WAIT: begin
          if (wake_wait) begin
            next_state.power = rmpc_pkg::RMPC_PWR_RUN;
          end
        end
        rmpc_pkg::RMPC_PWR_PSTOP: begin
          if (wake_pstop) begin
            next_state.power = rmpc_pkg::RMPC_PWR_RUN;
          end
        end
        rmpc_pkg::RMPC_PWR_STOP: begin
          if (wake_stop) begin
            next_state.power = rmpc_pkg::RMPC_PWR_RUN;
          end
        end
        default: begin
          next_state.power = rmpc_pkg::RMPC_PWR_RUN;
        end
      endcase

      // Mode bit may only move from special to normal; the reverse would bypass the strap
      if (rmpc_wr_hit(reg_write, reg_addr, rmpc_pkg::REG_MODE)) begin
        if (reg_wdata[0] && state.mode_strap_bit == rmpc_pkg::MODE_SPECIAL) begin
          next_state.mode_strap_bit = rmpc_pkg::MODE_NORMAL;
        end
      end

      if (rmpc_wr_hit(reg_write, reg_addr, rmpc_pkg::REG_CTRL)) begin
        next_state.osc_sel = reg_wdata[rmpc_pkg::CTRL_OSC_SEL];
        next_state.pstop_sel = reg_wdata[rmpc_pkg::CTRL_PSTOP_SEL];
        next_state.can_wake_en = reg_wdata[rmpc_pkg::CTRL_CAN_WAKE];
        next_state.freeze_en = reg_wdata[rmpc_pkg::CTRL_FREEZE];
        if (reg_wdata[rmpc_pkg::CTRL_DEBUG_EXIT]) begin
          next_state.debug_state = 1'b0;
        end
      end

      if (rmpc_wr_hit(reg_write, reg_addr, rmpc_pkg::REG_GATE)) begin
        next_state.periph_gate = reg_wdata;
      end

      // Read data stands for the one cycle after the strobe only
      next_state.rdata = 8'h00;
      if (reg_read) begin
        case (reg_addr)
          rmpc_pkg::REG_MODE: begin
            next_state.rdata = {7'h00, state.mode_strap_bit};
          end
          rmpc_pkg::REG_CTRL: begin
            next_state.rdata = {4'h0, state.freeze_en, state.can_wake_en, state.pstop_sel, state.osc_sel};
          end
          rmpc_pkg::REG_GATE: begin
            next_state.rdata = state.periph_gate;
          end
          rmpc_pkg::REG_STATUS: begin
            next_state.rdata = {2'h0, state.cause, state.debug_state, state.secured, state.power};
          end
          default: begin
            next_state.rdata = 8'h00;
          end
        endcase
      end
    end
  end

  // The whole state is registered at once
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Reset pin is open drain: only ever pulled low
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = (state.phase == rmpc_pkg::RMPC_PHASE_DRIVE);

  // Debug line serial traffic belongs to the debug controller, so this block never drives it
  assign debug_line_pin_out = 1'b0;
  assign debug_line_pin_oe = 1'b0;

  assign sys_reset_n = running;
  assign fetch_reset_vector = state.fetch_pulse;
  assign reg_rdata = state.rdata;

  // Clock gating per power mode; a limitation: peripheral gates only act in wait, run keeps all on
  always_comb begin
    clocks.use_crystal = running && state.osc_sel;
    clocks.crystal_pins_gpio = !clocks.use_crystal;
    clocks.cpu_clock_en = running && (state.power == rmpc_pkg::RMPC_PWR_RUN) && !debug.freeze_active;
    clocks.osc_run = (state.power != rmpc_pkg::RMPC_PWR_STOP);
    clocks.tick_wdog_clock_en = (state.power != rmpc_pkg::RMPC_PWR_STOP);
    clocks.api_clock_en = 1'b1;
    case (state.power)
      rmpc_pkg::RMPC_PWR_RUN: begin
        clocks.periph_clock_en = 8'hFF;
      end
      rmpc_pkg::RMPC_PWR_WAIT: begin
        clocks.periph_clock_en = state.periph_gate;
      end
      default: begin
        clocks.periph_clock_en = 8'h00;
      end
    endcase
  end

  // Debug and security gating
  always_comb begin
    debug.background_debug_state = state.debug_state;
    debug.freeze_active = state.debug_state && state.freeze_en;
    debug.debug_full = running && !state.secured;
    debug.debug_restricted = running && state.secured && (state.mode_strap_bit == rmpc_pkg::MODE_SPECIAL);
    debug.nvm_external_access = running && !state.secured;
    debug.nvm_cmd_restricted = state.secured;
  end

endmodule

// ### sim/rmpc_properties.sv
// Purpose: Port-level timing checks for the reset, mode and power block
// Assumes: One clock domain; the bench holds security_bits steady while reset is released
// Notes: Bound to rmpc_top; only relations visible at its ports are watched
`timescale 1ns/1ps
module rmpc_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reset_pin_in,
  input wire logic reset_pin_oe,
  input wire logic watchdog_timer_reset,
  input wire logic clock_monitor_reset,
  input wire logic [1:0] security_bits,
  input wire logic wait_instruction,
  input wire rmpc_pkg::rmpc_wake_type wake,
  input wire logic sys_reset_n,
  input wire logic fetch_reset_vector,
  input wire rmpc_pkg::rmpc_clocks_type clocks,
  input wire rmpc_pkg::rmpc_debug_type debug
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [5:0] oe_cycles;
  // Length of the current pin drive, so a short or long drive shows up when it ends
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oe_cycles <= 6'h00;
    end else begin
      oe_cycles <= reset_pin_oe ? oe_cycles + 6'h01 : 6'h00;
    end
  end
  drive_on_cause_a: assert property (
    sys_reset_n && reset_pin_in && $past(reset_pin_in) && $past(reset_pin_in, 2)
    && (watchdog_timer_reset || clock_monitor_reset) |=> reset_pin_oe && !sys_reset_n)
    else $error("reset pin not driven after internal cause");
  drive_length_a: assert property ($fell(reset_pin_oe) |-> oe_cycles == 6'(rmpc_pkg::RESET_DRIVE_CYCLES))
    else $error("reset pin drive has wrong length");
  release_mode_a: assert property (
    $rose(sys_reset_n) |-> fetch_reset_vector != debug.background_debug_state)
    else $error("release neither fetches nor enters debug");
  fetch_pulse_a: assert property (fetch_reset_vector |-> $rose(sys_reset_n) ##1 !fetch_reset_vector)
    else $error("fetch pulse not a single release cycle");
  reset_clocks_a: assert property (!sys_reset_n |-> !clocks.use_crystal && clocks.crystal_pins_gpio)
    else $error("crystal in use during reset");
  sec_decode_a: assert property (
    $rose(sys_reset_n) |-> debug.debug_full == (security_bits == rmpc_pkg::SEC_UNSECURED))
    else $error("security decode wrong at release");
  sec_gate_a: assert property (
    sys_reset_n |-> debug.nvm_external_access == debug.debug_full
    && debug.nvm_cmd_restricted != debug.debug_full && !(debug.debug_full && debug.debug_restricted))
    else $error("secured gating inconsistent");
  wait_gate_a: assert property (
    sys_reset_n && clocks.cpu_clock_en && wait_instruction && reset_pin_in
    && !watchdog_timer_reset && !clock_monitor_reset |=> !clocks.cpu_clock_en && clocks.osc_run)
    else $error("wait did not gate the cpu clock");
  nmi_wake_a: assert property (
    sys_reset_n && !clocks.cpu_clock_en && !debug.freeze_active && wake.nonmaskable_irq_input
    |=> clocks.cpu_clock_en)
    else $error("nonmaskable wake ignored");
  stop_all_a: assert property (
    sys_reset_n && !clocks.osc_run |-> !clocks.cpu_clock_en && !clocks.tick_wdog_clock_en
    && clocks.periph_clock_en == 8'h00)
    else $error("clock left running in full stop");
  freeze_a: assert property (debug.freeze_active |-> debug.background_debug_state && !clocks.cpu_clock_en)
    else $error("freeze outside debug or cpu still clocked");
endmodule
bind rmpc_top rmpc_properties u_props (.*);

// ### sim/rmpc_pin_model.sv
// Purpose: Board side of the reset pin and the mode strap
// Assumes: Both lines carry pull-ups; the device only ever pulls them low
// Notes: The strap is held just past reset release, then let go to the pull-up
`timescale 1ns/1ps
module rmpc_pin_model #(
  parameter int HOLD_CYCLES = 8
) (
  input wire logic clock,
  input wire logic pull_low,
  input wire logic strap_req,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic debug_line_pin_out,
  input wire logic debug_line_pin_oe,
  output logic reset_level,
  output logic strap_level
);
  int hold_cnt = 0;
  // Wired level of the reset line: either party pulling wins, else the pull-up
  assign reset_level = !(pull_low || (reset_pin_oe && !reset_pin_out));
  // Hold time restarts while reset is low; once spent, the driver lets go
  always @(posedge clock) begin
    hold_cnt <= reset_level ? (hold_cnt > 0 ? hold_cnt - 1 : 0) : HOLD_CYCLES;
  end
  // Requested strap across the release, otherwise the pull-up unless the device pulls
  assign strap_level = !(debug_line_pin_oe && !debug_line_pin_out)
    && ((hold_cnt > 0 || !reset_level) ? strap_req : 1'h1);
endmodule

// ### sim/rmpc_top_tb.sv
// Purpose: Self-checking bench for the reset, mode and power block
// Assumes: Board pins come from the pin model; registers through the plain port
// Notes: Expected values come from a small integer model kept beside the design
`timescale 1ns/1ps
module rmpc_top_tb;
  logic clock = 1'h0, rst_n = 1'h0, pull_low = 1'h1, strap_req = 1'h1;
  logic wdog = 1'h0, clkmon = 1'h0, wait_i = 1'h0, stop_i = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
  logic [1:0] sec = 2'h2;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, e_ctrl, e_gate, w;
  rmpc_pkg::rmpc_wake_type wake = '0;
  rmpc_pkg::rmpc_clocks_type clocks;
  rmpc_pkg::rmpc_debug_type debug;
  logic reset_level, strap_level, pin_out, pin_oe, dbg_out, dbg_oe, sys_reset_n, fetch;
  int mismatches = 0, cmp_count = 0, seed = 52056, e_mode, e_sec, e_pow, e_cause, e_dbg;
  initial begin
    forever #10 clock = ~clock;
  end
  rmpc_top u_dut (.clock(clock), .rst_n(rst_n), .reset_pin_in(reset_level), .reset_pin_out(pin_out),
    .reset_pin_oe(pin_oe), .debug_line_pin_in(strap_level), .debug_line_pin_out(dbg_out),
    .debug_line_pin_oe(dbg_oe), .watchdog_timer_reset(wdog), .clock_monitor_reset(clkmon),
    .security_bits(sec), .wait_instruction(wait_i), .stop_instruction(stop_i), .wake(wake),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sys_reset_n(sys_reset_n), .fetch_reset_vector(fetch), .clocks(clocks), .debug(debug));
  rmpc_pin_model u_pins (.clock(clock), .pull_low(pull_low), .strap_req(strap_req), .reset_pin_out(pin_out),
    .reset_pin_oe(pin_oe), .debug_line_pin_out(dbg_out), .debug_line_pin_oe(dbg_oe),
    .reset_level(reset_level), .strap_level(strap_level));
  // Counted comparison; unknown bits match only unknown bits in the expectation
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Single-cycle strobes, read data taken in the cycle after the read strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clock);
    reg_write <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clock);
    reg_read <= 1'h0;
    @(negedge clock);
    chk(reg_rdata, exp);
  endtask
  task automatic rs();
    rd(rmpc_pkg::REG_STATUS, {2'h0, e_cause[1:0], e_dbg[0], e_sec[0], e_pow[1:0]});
  endtask
  // Bounded wait for the internal reset to lift; running out ends the run
  task automatic wait_run(input logic s, input logic [1:0] sc);
    for (int i = 0; i < 300 && sys_reset_n !== 1'h1; i++) begin
      @(posedge clock);
    end
    if (sys_reset_n !== 1'h1) begin
      mismatches++;
      close_out();
    end
    @(negedge clock);
    e_mode = s;
    e_dbg = !s;
    e_sec = (sc != rmpc_pkg::SEC_UNSECURED);
    e_pow = 0;
  endtask
  // Board reset; the pull is let go after a random delay to model a slow source
  task automatic pin_rst(input logic s, input logic [1:0] sc, input logic por);
    @(posedge clock);
    strap_req <= s;
    sec <= sc;
    pull_low <= 1'h1;
    rst_n <= !por;
    repeat (20) @(posedge clock);
    rst_n <= 1'h1;
    repeat (4 + ($random(seed) & 7)) @(posedge clock);
    pull_low <= 1'h0;
    wait_run(s, sc);
    e_cause = 0;
  endtask
  // Watchdog or clock monitor request while running
  task automatic int_rst(input logic wd, input logic s, input logic [1:0] sc);
    @(posedge clock);
    strap_req <= s;
    sec <= sc;
    wdog <= wd;
    clkmon <= !wd;
    @(posedge clock);
    wdog <= 1'h0;
    clkmon <= 1'h0;
    @(negedge clock);
    chk({6'h00, pin_oe, sys_reset_n}, 8'h02);
    wait_run(s, sc);
    e_cause = wd ? 1 : 2;
  endtask
  task automatic enter(input logic stp);
    @(posedge clock);
    stop_i <= stp;
    wait_i <= !stp;
    @(posedge clock);
    stop_i <= 1'h0;
    wait_i <= 1'h0;
  endtask
  task automatic wk(input logic [7:0] v);
    @(posedge clock);
    wake <= rmpc_pkg::rmpc_wake_type'(v);
    @(posedge clock);
    wake <= '0;
  endtask
  // Power state after one wake vector: 1 wait, 2 pseudo-stop, 3 full stop
  function automatic int nxt(input int p, input logic [7:0] v);
    // An unmasked maskable interrupt ends every low-power mode, full stop included
    if (v[7] || (v[6] && !v[5]) || (p == 1 && v[4]) || (p == 2 && |v[3:1])
        || (p == 3 && (v[1] || (v[0] && e_ctrl[2])))) begin
      return 0;
    end
    return p;
  endfunction
  initial begin
    e_ctrl = 8'h00;
    e_gate = rmpc_pkg::GATE_RESET;
    pin_rst(1'h1, 2'h2, 1'h1);
    rd(rmpc_pkg::REG_MODE, 8'h01);
    rs();
    rd(rmpc_pkg::REG_CTRL, e_ctrl);
    rd(rmpc_pkg::REG_GATE, e_gate);
    chk({6'h00, clocks.use_crystal, clocks.crystal_pins_gpio}, 8'h01);
    chk({5'h00, debug.debug_full, debug.debug_restricted, debug.nvm_external_access}, 8'h05);
    // Unmapped places read zero and swallow writes
    for (int a = 4; a < 16; a++) begin
      wr(4'(a), 8'hA5);
      rd(4'(a), 8'h00);
    end
    // Each low-power mode against each wake bit, with a random interrupt mask
    for (int p = 1; p < 4; p++) begin
      for (int b = 0; b < 8; b++) begin
        e_gate = 8'($random(seed));
        e_ctrl = {5'h00, 1'($random(seed)), p == 2, 1'h0};
        wr(rmpc_pkg::REG_GATE, e_gate);
        wr(rmpc_pkg::REG_CTRL, e_ctrl);
        rd(rmpc_pkg::REG_CTRL, e_ctrl);
        enter(p != 1);
        e_pow = p;
        @(negedge clock);
        chk({clocks.cpu_clock_en, clocks.osc_run, 6'h00}, {1'h0, p != 3, 6'h00});
        chk({6'h00, clocks.tick_wdog_clock_en, clocks.api_clock_en}, {6'h00, p != 3, 1'h1});
        chk(clocks.periph_clock_en, (p == 1) ? e_gate : 8'h00);
        rs();
        w = (8'h01 << b) | (8'($random(seed)) & 8'h20);
        wk(w);
        e_pow = nxt(p, w);
        rs();
        wk(8'h80);
        e_pow = 0;
        rs();
      end
    end
    // Watchdog reset into special mode on a secured part
    int_rst(1'h1, 1'h0, 2'h1);
    rd(rmpc_pkg::REG_MODE, 8'h00);
    rs();
    chk({7'h00, debug.debug_restricted}, 8'h01);
    wr(rmpc_pkg::REG_CTRL, 8'h08);
    @(negedge clock);
    chk({6'h00, debug.freeze_active, clocks.cpu_clock_en}, 8'h02);
    wr(rmpc_pkg::REG_CTRL, 8'h18);
    e_dbg = 0;
    @(negedge clock);
    chk({6'h00, debug.freeze_active, clocks.cpu_clock_en}, 8'h01);
    rs();
    wr(rmpc_pkg::REG_MODE, 8'h01);
    rd(rmpc_pkg::REG_MODE, 8'h01);
    wr(rmpc_pkg::REG_MODE, 8'h00);
    rd(rmpc_pkg::REG_MODE, 8'h01);
    // Crystal selected, then a clock monitor reset must fall back to the internal reference
    wr(rmpc_pkg::REG_CTRL, 8'h01);
    @(negedge clock);
    chk({7'h00, clocks.use_crystal}, 8'h01);
    int_rst(1'h0, 1'h1, 2'h0);
    chk({6'h00, clocks.use_crystal, clocks.crystal_pins_gpio}, 8'h01);
    chk({5'h00, debug.debug_full, debug.debug_restricted, debug.nvm_external_access}, 8'h00);
    rs();
    // Pin resets over every security code, strap alternating
    for (int s = 0; s < 4; s++) begin
      pin_rst(1'(s), 2'(s), 1'h0);
      rd(rmpc_pkg::REG_MODE, {7'h00, e_mode[0]});
      rs();
    end
    close_out();
  end
endmodule
